// >>> trl_consts.vh
`ifndef TRL_CONSTS_VH
`define TRL_CONSTS_VH
// ----------------------------------------
// port addresses
// ----------------------------------------
`define TRL_ADDR_CNT0      2'h0
`define TRL_ADDR_CNT1      2'h1
`define TRL_ADDR_CNT2      2'h2
`define TRL_ADDR_CMD       2'h3
// ----------------------------------------
// command word fields
// ----------------------------------------
`define TRL_CW_SEL_HI      7
`define TRL_CW_SEL_LO      6
`define TRL_CW_FMT_HI      5
`define TRL_CW_FMT_LO      4
`define TRL_CW_RB_CNT_N    5
`define TRL_CW_RB_STS_N    4
`define TRL_CW_RB_T2       3
`define TRL_CW_RB_T1       2
`define TRL_CW_RB_T0       1
`define TRL_CW_RB_ZERO     0
`define TRL_SEL_READBACK   2'h3
// ----------------------------------------
// byte formats
// ----------------------------------------
`define TRL_FMT_LATCH      2'h0
`define TRL_FMT_LSB        2'h1
`define TRL_FMT_MSB        2'h2
`define TRL_FMT_BOTH       2'h3
// ----------------------------------------
// status byte fields and reset values
// ----------------------------------------
`define TRL_ST_OUT         7
`define TRL_ST_NULL        6
`define TRL_MODE_RST       6'h00
`define TRL_DATA_RST       8'h00
`define TRL_WORD_RST       16'h0000
`endif

// >>> trl_chan.v
`timescale 1ns/1ps
`include "trl_consts.vh"
// ----------------------------------------
// per-counter readback state
// ----------------------------------------
module trl_chan (
  input  wire        clk_in,         // system clock
  input  wire        srst_in,        // sync reset
  input  wire        prog_in,        // command word for this counter
  input  wire [5:0]  prog_mode_in,   // mode fields of that word
  input  wire        latch_cnt_in,   // count latch request
  input  wire        latch_sts_in,   // status latch request
  input  wire        wr_in,          // count byte write
  input  wire        rd_in,          // port read
  input  wire        load_in,        // preload moved to counting element
  input  wire        pin_in,         // live output pin level
  input  wire [15:0] live_in,        // counting element value
  output reg  [7:0]  rd_data_out,    // byte for this read
  output reg  [5:0]  mode_out,       // current mode fields
  output reg         null_out        // null-count flag
);
  reg  [15:0] snapshot_latch_r;      // latched count
  reg         cnt_held_r;            // count snapshot pending
  reg  [7:0]  sts_r;                 // latched status
  reg         sts_held_r;            // status pending
  reg         rd_ptr_r;              // read byte order: 1 = msb next
  reg         wr_ptr_r;              // write byte order: 1 = msb next
  wire [1:0]  fmt = mode_out[5:4];   // byte format
  wire [15:0] src = cnt_held_r ? snapshot_latch_r : live_in;
  wire        last_rd = (fmt != `TRL_FMT_BOTH) | rd_ptr_r;
  // ----------------------------------------
  // read byte select
  // ----------------------------------------
  always @* begin
    if (sts_held_r) begin
      rd_data_out = sts_r;
    end else if (fmt == `TRL_FMT_MSB || (fmt == `TRL_FMT_BOTH && rd_ptr_r)) begin
      rd_data_out = src[15:8];
    end else begin
      rd_data_out = src[7:0];
    end
  end
  // ----------------------------------------
  // latch, pointer and null-count state
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (srst_in) begin
      snapshot_latch_r <= `TRL_WORD_RST;
      cnt_held_r       <= 1'b0;
      sts_r            <= `TRL_DATA_RST;
      sts_held_r       <= 1'b0;
      rd_ptr_r         <= 1'b0;
      wr_ptr_r         <= 1'b0;
      mode_out         <= `TRL_MODE_RST;
      null_out         <= 1'b0;
    end else if (prog_in) begin
      // reprogramming drops snapshots and restarts byte order
      mode_out   <= prog_mode_in;
      cnt_held_r <= 1'b0;
      sts_held_r <= 1'b0;
      rd_ptr_r   <= 1'b0;
      wr_ptr_r   <= 1'b0;
      null_out   <= 1'b1;
    end else begin
      // count latch, first one wins; live value is the element's
      if (latch_cnt_in && !cnt_held_r) begin
        snapshot_latch_r <= live_in;
        cnt_held_r       <= 1'b1;
      end
      // status latch, first one wins
      if (latch_sts_in && !sts_held_r) begin
        sts_r      <= {pin_in, null_out, mode_out};
        sts_held_r <= 1'b1;
      end
      // reads: status first, then count bytes
      if (rd_in) begin
        if (sts_held_r) begin
          sts_held_r <= 1'b0;
        end else begin
          if (fmt == `TRL_FMT_BOTH) begin
            rd_ptr_r <= ~rd_ptr_r;
          end
          if (last_rd) begin
            cnt_held_r <= 1'b0;
          end
        end
      end
      // writes: own pointer; null set on last byte, load clears
      if (wr_in) begin
        if (fmt == `TRL_FMT_BOTH) begin
          wr_ptr_r <= ~wr_ptr_r;
        end
        if (fmt != `TRL_FMT_BOTH || wr_ptr_r) begin
          null_out <= 1'b1;
        end else if (load_in) begin
          null_out <= 1'b0;
        end
      end else if (load_in) begin
        null_out <= 1'b0;
      end
    end
  end
endmodule

// >>> trl_top.v
`timescale 1ns/1ps
`include "trl_consts.vh"
// How it works
// - second count latch ignored while unread
// - reads follow byte format, interleaving allowed
// - separate read and write byte pointers
// - top bits both set means readback
// - readback latches each selected counter separately
// - repeated count readbacks keep first snapshot
// - status readable only after status latch
// - status: pin, null flag, mode bits
// - command word sets null flag there only
// - count write sets null, last byte
// - load into element clears null flag
// - latch shows element value, not preload
// - repeated status latches keep first status
// - count and status latched together
// - status read first, then count bytes
// - address decode; read at three undriven
// - readback only through command port write
// - format zero is count latch command
// - format selects lsb, msb or both
module trl_top #(
  parameter NCH = 3                                  // counters
) (
  input  wire        clk_in,         // system clock, 125 MHz
  input  wire        srst_in,        // sync reset, active high
  input  wire        cs_n_in,        // chip select, active low
  input  wire        rd_n_in,        // read strobe, active low
  input  wire        wr_n_in,        // write strobe, active low
  input  wire        port_sel_hi_in, // address high
  input  wire        port_sel_lo_in, // address low
  input  wire [7:0]  data_in,        // bus write data
  input  wire [47:0] live_cnt_in,    // counting element values, 16 each
  input  wire [2:0]  pin_state_in,   // output pin levels
  input  wire [2:0]  load_evt_in,    // count-loaded pulses
  output reg  [7:0]  data_out,       // bus read data
  output reg         data_oe_n_out,  // low while driving bus
  output reg  [2:0]  wr_strobe_out,  // count byte write per counter
  output reg  [7:0]  wr_data_out,    // byte for counting core
  output reg  [17:0] mode_out,       // mode fields, 6 per counter
  output reg  [2:0]  null_cnt_out    // null-count flags
);
  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  reg        rd_q_r;                 // read strobe, last cycle
  reg        wr_q_r;                 // write strobe, last cycle
  wire [1:0] addr   = {port_sel_hi_in, port_sel_lo_in};
  wire       rd_act = !cs_n_in && !rd_n_in && wr_n_in;
  wire       wr_act = !cs_n_in && !wr_n_in && rd_n_in;
  wire       rd_go  = rd_act && !rd_q_r;     // one event per strobe
  wire       wr_go  = wr_act && !wr_q_r;
  wire       cmd_wr = wr_go && addr == `TRL_ADDR_CMD;
  wire       is_rb  = data_in[`TRL_CW_SEL_HI] && data_in[`TRL_CW_SEL_LO];
  wire [1:0] cw_fmt = {data_in[`TRL_CW_FMT_HI], data_in[`TRL_CW_FMT_LO]};
  wire [1:0] cw_sel = {data_in[`TRL_CW_SEL_HI], data_in[`TRL_CW_SEL_LO]};
  wire       rb_ok  = cmd_wr && is_rb && !data_in[`TRL_CW_RB_ZERO];
  wire [2:0] rb_sel = {data_in[`TRL_CW_RB_T2], data_in[`TRL_CW_RB_T1],
                       data_in[`TRL_CW_RB_T0]};
  // ----------------------------------------
  // per-counter strobes
  // ----------------------------------------
  reg  [2:0] prog;                   // command word hits counter
  reg  [2:0] lat_c;                  // count latch request
  reg  [2:0] lat_s;                  // status latch request
  reg  [2:0] wr_c;                   // count byte write
  reg  [2:0] rd_c;                   // port read
  wire [7:0] ch_rd  [0:2];           // per-counter read byte
  wire [5:0] ch_mode[0:2];
  wire [2:0] ch_null;
  integer    i;
  // decode command and port strobes
  always @* begin
    for (i = 0; i < NCH; i = i + 1) begin
      prog[i]  = cmd_wr && !is_rb && cw_sel == i[1:0] &&
                 cw_fmt != `TRL_FMT_LATCH;
      lat_c[i] = (cmd_wr && !is_rb && cw_sel == i[1:0] &&
                  cw_fmt == `TRL_FMT_LATCH) ||
                 (rb_ok && rb_sel[i] && !data_in[`TRL_CW_RB_CNT_N]);
      lat_s[i] = rb_ok && rb_sel[i] && !data_in[`TRL_CW_RB_STS_N];
      wr_c[i]  = wr_go && addr == i[1:0];
      rd_c[i]  = rd_go && addr == i[1:0];
    end
  end
  // ----------------------------------------
  // counters
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : ch
      trl_chan u_chan (
        .clk_in       (clk_in),
        .srst_in      (srst_in),
        .prog_in      (prog[g]),
        .prog_mode_in (data_in[5:0]),
        .latch_cnt_in (lat_c[g]),
        .latch_sts_in (lat_s[g]),
        .wr_in        (wr_c[g]),
        .rd_in        (rd_c[g]),
        .load_in      (load_evt_in[g]),
        .pin_in       (pin_state_in[g]),
        .live_in      (live_cnt_in[16*g +: 16]),
        .rd_data_out  (ch_rd[g]),
        .mode_out     (ch_mode[g]),
        .null_out     (ch_null[g])
      );
    end
  endgenerate
  // ----------------------------------------
  // registered bus outputs
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (srst_in) begin
      rd_q_r        <= 1'b0;
      wr_q_r        <= 1'b0;
      data_out      <= `TRL_DATA_RST;
      data_oe_n_out <= 1'b1;
      wr_strobe_out <= 3'h0;
      wr_data_out   <= `TRL_DATA_RST;
      mode_out      <= 18'h0_0000;
      null_cnt_out  <= 3'h0;
    end else begin
      rd_q_r        <= rd_act;
      wr_q_r        <= wr_act;
      wr_strobe_out <= wr_c;
      wr_data_out   <= data_in;
      mode_out      <= {ch_mode[2], ch_mode[1], ch_mode[0]};
      null_cnt_out  <= ch_null;
      // drive during a counter read; address three stays undriven
      if (rd_act && addr != `TRL_ADDR_CMD) begin
        data_oe_n_out <= 1'b0;
        if (rd_go) begin
          data_out <= ch_rd[addr];
        end
      end else begin
        data_oe_n_out <= 1'b1;
      end
    end
  end
endmodule

// >>> trl_top_chk.sv
`timescale 1ns/1ps
// ----------------------------------------
// port-level checks of the readback path
// ----------------------------------------
module trl_top_chk #(
  parameter NCH = 3                   // counters
) (
  input logic        clk_in,          // system clock
  input logic        srst_in,         // sync reset
  input logic        cs_n_in,         // chip select
  input logic        rd_n_in,         // read strobe
  input logic        wr_n_in,         // write strobe
  input logic        port_sel_hi_in,  // address high
  input logic        port_sel_lo_in,  // address low
  input logic [7:0]  data_in,         // write data
  input logic [2:0]  load_evt_in,     // load pulses
  input logic [7:0]  data_out,        // read data
  input logic        data_oe_n_out,   // bus drive enable
  input logic [2:0]  wr_strobe_out,   // count byte strobes
  input logic [7:0]  wr_data_out,     // count byte
  input logic [17:0] mode_out,        // mode fields
  input logic [2:0]  null_cnt_out     // null flags
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  logic       p_rd;                   // read active last cycle
  logic       p_wr;                   // write active last cycle
  logic [1:0] sel_r;                  // address of last write
  logic [1:0] cw_r;                   // counter named by last write
  wire  [1:0] adr    = {port_sel_hi_in, port_sel_lo_in};
  wire        rd_act = !cs_n_in && !rd_n_in && wr_n_in;
  wire        wr_act = !cs_n_in && !wr_n_in && rd_n_in;
  wire        rd_go  = rd_act && !p_rd;   // one event per strobe
  wire        wr_go  = wr_act && !p_wr;
  wire        cw_go  = wr_go && adr == 2'h3 && data_in[7:6] != 2'h3 && data_in[5:4] != 2'h0;
  // remember strobe state and the target of each write
  always @(posedge clk_in) begin
    p_rd <= rd_act;
    p_wr <= wr_act;
    if (wr_go) begin
      sel_r <= adr;
      cw_r  <= data_in[7:6];
    end
  end
  a_read_drive: assert property (rd_go && adr != 2'h3 |=> !data_oe_n_out)
    else $error("read did not drive the bus");
  a_nop_quiet: assert property (rd_go && adr == 2'h3 |=> data_oe_n_out [*2])
    else $error("read at command port drove the bus");
  a_oe_release: assert property (rd_n_in ##1 rd_n_in |-> data_oe_n_out)
    else $error("bus driven without a read");
  a_count_write: assert property (wr_go && adr != 2'h3 |=>
    wr_strobe_out == (3'h1 << sel_r) && wr_data_out == $past(data_in))
    else $error("count byte write not passed on");
  a_cmd_nowrite: assert property (wr_go && adr == 2'h3 |=> wr_strobe_out == 3'h0)
    else $error("command write reached a counter");
  // flags and modes reach the ports two edges after the command: counter, then port register
  a_null_set: assert property (cw_go && load_evt_in == 3'h0 |-> ##2 null_cnt_out[cw_r] &&
    (null_cnt_out & ~(3'h1 << cw_r)) == ($past(null_cnt_out) & ~(3'h1 << cw_r)))
    else $error("null flag wrong after command word");
  a_mode_keep: assert property (cw_go |-> ##2
    mode_out[6*cw_r +: 6] == $past(data_in[5:0], 2))
    else $error("mode fields not stored");
  a_null_clear: assert property (load_evt_in != 3'h0 && !wr_go |-> ##2
    (null_cnt_out & $past(load_evt_in, 2)) == 3'h0)
    else $error("null flag not cleared on load");
  a_data_hold: assert property (!rd_go |=> $stable(data_out))
    else $error("read data changed without a read");
endmodule

// >>> trl_core_mdl.sv
`timescale 1ns/1ps
// ----------------------------------------
// counting core stand-in
// ----------------------------------------
module trl_core_mdl (
  input  wire        clk_in,        // system clock
  input  wire        srst_in,       // sync reset
  input  wire [2:0]  wr_strobe_in,  // count byte strobes
  input  wire [7:0]  wr_data_in,    // count byte
  input  wire [2:0]  go_in,         // move preload to element
  output reg  [47:0] live_out,      // element values
  output wire [2:0]  pin_out,       // output pin levels
  output reg  [2:0]  load_out       // load pulses
);
  reg [15:0] pre_r [0:2];           // preload holding per counter
  integer    i;
  initial live_out = 48'h3c58_3c5b_3c5a;  // elements keep their values across reset
  initial load_out = 3'h0;
  assign pin_out = {live_out[32], live_out[16], live_out[0]};  // pin follows bit 0
  // bytes shift in from the top: lsb then msb lands as one word
  always @(posedge clk_in) begin
    load_out <= go_in;
    for (i = 0; i < 3; i = i + 1) begin
      if (srst_in) pre_r[i] <= 16'h0000;
      else if (wr_strobe_in[i]) pre_r[i] <= {wr_data_in, pre_r[i][15:8]};
      if (go_in[i]) live_out[16*i +: 16] <= pre_r[i];
    end
  end
endmodule

// >>> trl_top_tb.sv
`timescale 1ns/1ps
// ----------------------------------------
// readback path bench
// ----------------------------------------
module trl_top_tb;
  logic clk_in = 0, srst_in = 1, cs_n_in = 1, rd_n_in = 1, wr_n_in = 1;
  logic port_sel_hi_in = 0, port_sel_lo_in = 0;
  logic [7:0]  data_in = 8'h00;
  logic [2:0]  go_r = 3'h0;         // element load requests
  wire  [47:0] live;
  wire  [2:0]  pins, loads, wr_strobe_out, null_cnt_out;
  wire  [7:0]  data_out, wr_data_out;
  wire         data_oe_n_out;
  wire  [17:0] mode_out;
  int          bad_count = 0, tests_run = 0, cyc = 0;
  always #4 clk_in = ~clk_in;
  trl_top trl_top_i (.clk_in, .srst_in, .cs_n_in, .rd_n_in, .wr_n_in, .port_sel_hi_in,
    .port_sel_lo_in, .data_in, .live_cnt_in(live), .pin_state_in(pins), .load_evt_in(loads),
    .data_out, .data_oe_n_out, .wr_strobe_out, .wr_data_out, .mode_out, .null_cnt_out);
  trl_core_mdl trl_core_mdl_i (.clk_in, .srst_in, .wr_strobe_in(wr_strobe_out),
    .wr_data_in(wr_data_out), .go_in(go_r), .live_out(live), .pin_out(pins), .load_out(loads));
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, s);
      bad_count++;
    end
  endtask
  // one bus cycle, strobe held two edges then released for at least one
  task automatic acc(input logic [1:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_in);
    #1;
    {port_sel_hi_in, port_sel_lo_in} = a;
    data_in = d;
    cs_n_in = 0;
    wr_n_in = !w;
    rd_n_in = w;
    repeat (2) @(posedge clk_in);
    #1;
    cs_n_in = 1;
    wr_n_in = 1;
    rd_n_in = 1;
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    acc(a, 1'b1, d);
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    acc(a, 1'b0, 8'h00);
    chk("read_oe_n", {7'h00, a == 2'h3}, {7'h00, data_oe_n_out});
    if (a != 2'h3) chk("read_data", e, data_out);
  endtask
  task automatic go(input logic [2:0] m);
    @(posedge clk_in);
    #1;
    go_r = m;
    @(posedge clk_in);
    #1;
    go_r = 3'h0;
    repeat (2) @(posedge clk_in);
    #1;
  endtask
  task automatic rst();
    srst_in = 1;
    repeat (5) @(posedge clk_in);
    #1;
    srst_in = 0;
  endtask
  initial begin
    rst();
    // latch command and byte order
    wr(3, 8'h34); chk("null", 8'h01, {5'h00, null_cnt_out});
    wr(0, 8'h78); wr(0, 8'h56); go(3'h1); chk("null", 8'h00, {5'h00, null_cnt_out});
    wr(0, 8'h21); chk("null", 8'h00, {5'h00, null_cnt_out});
    wr(3, 8'h00); wr(0, 8'h43); chk("null", 8'h01, {5'h00, null_cnt_out});
    go(3'h1); wr(3, 8'h00);
    rd(0, 8'h78); rd(2, 8'h58); rd(0, 8'h56);
    rd(0, 8'h21); wr(0, 8'h11); rd(0, 8'h43); wr(0, 8'h22); go(3'h1);
    $display("test latch done");
    // count and status together, repeats ignored
    wr(3, 8'h64); wr(3, 8'hc6); wr(1, 8'h99); go(3'h2); wr(3, 8'hc6);
    rd(0, 8'hb4); rd(0, 8'h11); rd(0, 8'h22);
    rd(1, 8'he4); rd(1, 8'h3c); rd(1, 8'h99);
    $display("test readback done");
    // refused accesses and reset
    rd(3, 8'h00); wr(3, 8'he9); rd(2, 8'h58);
    wr(3, 8'h90); rd(2, 8'h58); rd(2, 8'h58);
    wr(2, 8'h77); chk("null", 8'h04, {5'h00, null_cnt_out});
    wr(3, 8'hd8); go(3'h4); rst(); rd(2, 8'h00);
    $display("test refusal done");
    report_and_stop();
  end
endmodule
bind trl_top trl_top_chk #(.NCH(NCH)) trl_top_chk_i (.clk_in, .srst_in, .cs_n_in, .rd_n_in,
  .wr_n_in, .port_sel_hi_in, .port_sel_lo_in, .data_in, .load_evt_in, .data_out,
  .data_oe_n_out, .wr_strobe_out, .wr_data_out, .mode_out, .null_cnt_out);
